// ### hdl/frl_pkg.sv
// Package: command codes, field layout, reset values and limit ranges
// for the fault response and limit register bank and its host.
// Assumes both ends share one clock and a synchronous active high reset.
// What this block does
// - Output overvoltage reaction code fixed at 10.
// - Restart policy accepts only 000 or 111.
// - Shutdown wait always zero, no delay.
// - Output overvoltage byte resets 0xb8, bits 5:3 writable.
// - Output overcurrent reaction code fixed at 11.
// - Output overcurrent byte resets 0xf8, bits 5:3 writable.
// - Overheat reaction 10, resets 0xb8, bits 5:3 writable.
// - Input overvoltage disables output, byte 0xc0 read-only.
// - Restart after input overvoltage clears.
// - Overcurrent trip 20..60 A, above alert.
// - Overcurrent alert 10..40 A, below trip.
// - Overheat trip 25..140 C, above alert.
// - Overheat alert 25..125 C, below trip.
// - Input overvoltage trip 48..90 V.
// - Output ok levels 8.1..13.2 V, gap 1.6 V.
// - Turn-on wait 10..500 ms.
// - Ramp time 15..500 ms.
// - Communication faults flagged in one status byte.
package frl_pkg;
    // Command codes on the link
    localparam logic [7:0] CMD_OUT_OV_REACT = 8'h41;
    localparam logic [7:0] CMD_OC_TRIP = 8'h46;
    localparam logic [7:0] CMD_OC_REACT = 8'h47;
    localparam logic [7:0] CMD_OC_ALERT = 8'h4a;
    localparam logic [7:0] CMD_OT_TRIP = 8'h4f;
    localparam logic [7:0] CMD_OT_REACT = 8'h50;
    localparam logic [7:0] CMD_OT_ALERT = 8'h51;
    localparam logic [7:0] CMD_IN_OV_TRIP = 8'h55;
    localparam logic [7:0] CMD_IN_OV_REACT = 8'h56;
    localparam logic [7:0] CMD_OK_ASSERT = 8'h5e;
    localparam logic [7:0] CMD_OK_DEASSERT = 8'h5f;
    localparam logic [7:0] CMD_TURN_ON_WAIT = 8'h60;
    localparam logic [7:0] CMD_RAMP_TIME = 8'h61;
    localparam logic [7:0] CMD_COMM_STATUS = 8'h7e;
    // Reaction byte layout
    localparam int POLICY_LSB = 3;
    localparam logic [2:0] POLICY_NEVER = 3'h0;
    localparam logic [2:0] POLICY_ALWAYS = 3'h7;
    localparam logic [7:0] OUT_OV_REACT_RST = 8'hb8;
    localparam logic [7:0] OC_REACT_RST = 8'hf8;
    localparam logic [7:0] OT_REACT_RST = 8'hb8;
    localparam logic [7:0] IN_OV_REACT_RST = 8'hc0;
    // Communication status bits
    localparam int COMM_BAD_CMD = 7;
    localparam int COMM_BAD_DATA = 6;
    // Limits in A, deg C, V, 10 mV and ms
    localparam logic [15:0] OC_TRIP_MIN = 16'h0014;
    localparam logic [15:0] OC_TRIP_MAX = 16'h003c;
    localparam logic [15:0] OC_ALERT_MIN = 16'h000a;
    localparam logic [15:0] OC_ALERT_MAX = 16'h0028;
    localparam logic [15:0] OT_TRIP_MIN = 16'h0019;
    localparam logic [15:0] OT_TRIP_MAX = 16'h008c;
    localparam logic [15:0] OT_ALERT_MIN = 16'h0019;
    localparam logic [15:0] OT_ALERT_MAX = 16'h007d;
    localparam logic [15:0] IN_OV_MIN = 16'h0030;
    localparam logic [15:0] IN_OV_MAX = 16'h005a;
    localparam logic [15:0] OK_MIN = 16'h032a;
    localparam logic [15:0] OK_MAX = 16'h0528;
    localparam logic [15:0] OK_GAP = 16'h00a0;
    localparam logic [15:0] TON_WAIT_MIN = 16'h000a;
    localparam logic [15:0] TON_RAMP_MIN = 16'h000f;
    localparam logic [15:0] TON_MAX = 16'h01f4;
    // Reset values of limits
    localparam logic [15:0] OC_TRIP_RST = 16'h0032;
    localparam logic [15:0] OC_ALERT_RST = 16'h0028;
    localparam logic [15:0] OT_TRIP_RST = 16'h007d;
    localparam logic [15:0] OT_ALERT_RST = 16'h006e;
    localparam logic [15:0] IN_OV_RST = 16'h004b;
    localparam logic [15:0] OK_ASSERT_RST = 16'h044c;
    localparam logic [15:0] OK_DEASSERT_RST = 16'h03ac;
    localparam logic [15:0] TON_WAIT_RST = 16'h000a;
    localparam logic [15:0] TON_RAMP_RST = 16'h000f;
    // Host Wishbone register offsets and control bits
    localparam logic [3:0] HR_CTRL = 4'h0;
    localparam logic [3:0] HR_CODE = 4'h4;
    localparam logic [3:0] HR_WDATA = 4'h8;
    localparam logic [3:0] HR_RDATA = 4'hc;
    localparam int CTRL_GO = 0;
    localparam int CTRL_WE = 1;
    localparam int STAT_BUSY = 0;
    localparam int STAT_DONE = 1;
    // Host sequencer states
    typedef enum logic [0:0] {
        FRL_H_IDLE = 1'b0,
        FRL_H_REQ = 1'b1
    } frl_hstate_t;
endpackage

// ### hdl/frl_link_if.sv
// Interface: command link between the host controller and the register bank.
// Assumes one clock; the bench joins both ends through it.
interface frl_link_if;
    logic req;
    logic we;
    logic [7:0] code;
    logic [15:0] wdata;
    logic ack;
    logic [15:0] rdata;
    // Register bank end
    modport dev (input req, input we, input code, input wdata, output ack, output rdata);
    // Host controller end
    modport host (output req, output we, output code, output wdata, input ack, input rdata);
endinterface

// ### hdl/frl_bank.sv
// Register bank end: fault reactions, limits with range checks, and
// output shutdown and restart. Fault inputs come from converter logic
// on the same clock, so they are not synchronised.
//
// Decided for this implementation: the Wishbone interface to the registers.
module frl_bank (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Link to host
    frl_link_if.dev link,
    // Converter side
    input wire logic on_cmd_i,
    input wire logic out_ov_i,
    input wire logic oc_i,
    input wire logic ot_i,
    input wire logic in_ov_i,
    output logic out_en_o,
    output logic [15:0] oc_trip_o,
    output logic [15:0] oc_alert_o,
    output logic [15:0] ot_trip_o,
    output logic [15:0] ot_alert_o,
    output logic [15:0] in_ov_trip_o,
    output logic [15:0] ok_assert_o,
    output logic [15:0] ok_deassert_o,
    output logic [15:0] turn_on_wait_o,
    output logic [15:0] ramp_time_o
);
    logic [2:0] ov_pol_q, oc_pol_q, ot_pol_q;
    logic [15:0] oc_trip_q, oc_alert_q, ot_trip_q, ot_alert_q, in_ov_q;
    logic [15:0] ok_on_q, ok_off_q, ton_wait_q, ton_ramp_q;
    logic [7:0] comm_q, comm_d;
    logic latch_q, latch_d;
    logic out_en_q;
    logic ack_q;
    logic [15:0] rdata_q;
    logic [15:0] rd_mux;

    // Request decode
    wire take = link.req & ~ack_q;
    wire wr = take & link.we;
    wire [15:0] wd = link.wdata;
    wire [2:0] new_pol = wd[frl_pkg::POLICY_LSB +: 3];
    wire pol_ok = (new_pol == frl_pkg::POLICY_NEVER) | (new_pol == frl_pkg::POLICY_ALWAYS);
    wire [2:0] no_wait = 3'h0;
    wire [7:0] ov_byte = {frl_pkg::OUT_OV_REACT_RST[7:6], ov_pol_q, no_wait};
    wire [7:0] oc_byte = {frl_pkg::OC_REACT_RST[7:6], oc_pol_q, no_wait};
    wire [7:0] ot_byte = {frl_pkg::OT_REACT_RST[7:6], ot_pol_q, no_wait};

    // Range and cross checks on write data
    // trip range
    wire ok_oc_trip = wd >= frl_pkg::OC_TRIP_MIN && wd <= frl_pkg::OC_TRIP_MAX
        && wd > oc_alert_q;
    wire ok_oc_alert = wd >= frl_pkg::OC_ALERT_MIN && wd <= frl_pkg::OC_ALERT_MAX
        && wd < oc_trip_q;
    wire ok_ot_trip = wd >= frl_pkg::OT_TRIP_MIN && wd <= frl_pkg::OT_TRIP_MAX
        && wd > ot_alert_q;
    wire ok_ot_alert = wd >= frl_pkg::OT_ALERT_MIN && wd <= frl_pkg::OT_ALERT_MAX
        && wd < ot_trip_q;
    wire ok_in_ov = wd >= frl_pkg::IN_OV_MIN && wd <= frl_pkg::IN_OV_MAX;
    wire ok_on = wd >= frl_pkg::OK_MIN && wd <= frl_pkg::OK_MAX
        && wd >= ok_off_q + frl_pkg::OK_GAP;
    wire ok_off = wd >= frl_pkg::OK_MIN && wd <= frl_pkg::OK_MAX
        && wd + frl_pkg::OK_GAP <= ok_on_q;
    wire ok_wait = wd >= frl_pkg::TON_WAIT_MIN && wd <= frl_pkg::TON_MAX;
    wire ok_ramp = wd >= frl_pkg::TON_RAMP_MIN && wd <= frl_pkg::TON_MAX;

    // Per-command code decodes
    wire is_ov_r = link.code == frl_pkg::CMD_OUT_OV_REACT;
    wire is_oc_t = link.code == frl_pkg::CMD_OC_TRIP;
    wire is_oc_r = link.code == frl_pkg::CMD_OC_REACT;
    wire is_oc_a = link.code == frl_pkg::CMD_OC_ALERT;
    wire is_ot_t = link.code == frl_pkg::CMD_OT_TRIP;
    wire is_ot_r = link.code == frl_pkg::CMD_OT_REACT;
    wire is_ot_a = link.code == frl_pkg::CMD_OT_ALERT;
    wire is_in_t = link.code == frl_pkg::CMD_IN_OV_TRIP;
    wire is_in_r = link.code == frl_pkg::CMD_IN_OV_REACT;
    wire is_on = link.code == frl_pkg::CMD_OK_ASSERT;
    wire is_off = link.code == frl_pkg::CMD_OK_DEASSERT;
    wire is_wait = link.code == frl_pkg::CMD_TURN_ON_WAIT;
    wire is_ramp = link.code == frl_pkg::CMD_RAMP_TIME;
    wire is_comm = link.code == frl_pkg::CMD_COMM_STATUS;
    wire known = is_ov_r | is_oc_t | is_oc_r | is_oc_a | is_ot_t | is_ot_r | is_ot_a
        | is_in_t | is_in_r | is_on | is_off | is_wait | is_ramp | is_comm;
    wire is_react = is_ov_r | is_oc_r | is_ot_r;
    // value accepted only when its check passes
    wire good = is_react ? pol_ok : is_oc_t ? ok_oc_trip : is_oc_a ? ok_oc_alert
        : is_ot_t ? ok_ot_trip : is_ot_a ? ok_ot_alert : is_in_t ? ok_in_ov
        : is_on ? ok_on : is_off ? ok_off : is_wait ? ok_wait : is_ramp ? ok_ramp : 1'b1;
    wire commit = wr & known & good;
    wire bad_data = wr & known & ~good;
    wire bad_cmd = take & ~known;

    // Read data selection
    assign rd_mux = is_ov_r ? {8'h00, ov_byte} : is_oc_r ? {8'h00, oc_byte}
        : is_ot_r ? {8'h00, ot_byte} : is_in_r ? {8'h00, frl_pkg::IN_OV_REACT_RST}
        : is_oc_t ? oc_trip_q : is_oc_a ? oc_alert_q : is_ot_t ? ot_trip_q
        : is_ot_a ? ot_alert_q : is_in_t ? in_ov_q : is_on ? ok_on_q
        : is_off ? ok_off_q : is_wait ? ton_wait_q : is_ramp ? ton_ramp_q
        : is_comm ? {8'h00, comm_q} : 16'h0000;

    // Communication status: flags set by faults win over a clearing write
    always_comb begin
        comm_d = comm_q;
        if (wr && is_comm) begin
            comm_d = comm_q & ~wd[7:0];
        end
        if (bad_cmd) begin
            comm_d[frl_pkg::COMM_BAD_CMD] = 1'b1;
        end
        if (bad_data) begin
            comm_d[frl_pkg::COMM_BAD_DATA] = 1'b1;
        end
    end

    // Link answer, one cycle after the request is taken
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            rdata_q <= 16'h0000;
            comm_q <= 8'h00;
        end else begin
            ack_q <= take;
            comm_q <= comm_d;
            if (take) begin
                rdata_q <= link.we ? 16'h0000 : rd_mux;
            end
        end
    end

    // Reaction policies; only bits 5:3 are stored
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ov_pol_q <= frl_pkg::OUT_OV_REACT_RST[5:3];
            oc_pol_q <= frl_pkg::OC_REACT_RST[5:3];
            ot_pol_q <= frl_pkg::OT_REACT_RST[5:3];
        end else if (commit) begin
            if (is_ov_r) ov_pol_q <= new_pol;
            if (is_oc_r) oc_pol_q <= new_pol;
            if (is_ot_r) ot_pol_q <= new_pol;
        end
    end

    // Limit values
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            oc_trip_q <= frl_pkg::OC_TRIP_RST;
            oc_alert_q <= frl_pkg::OC_ALERT_RST;
            ot_trip_q <= frl_pkg::OT_TRIP_RST;
            ot_alert_q <= frl_pkg::OT_ALERT_RST;
            in_ov_q <= frl_pkg::IN_OV_RST;
            ok_on_q <= frl_pkg::OK_ASSERT_RST;
            ok_off_q <= frl_pkg::OK_DEASSERT_RST;
            ton_wait_q <= frl_pkg::TON_WAIT_RST;
            ton_ramp_q <= frl_pkg::TON_RAMP_RST;
        end else if (commit) begin
            if (is_oc_t) oc_trip_q <= wd;
            if (is_oc_a) oc_alert_q <= wd;
            if (is_ot_t) ot_trip_q <= wd;
            if (is_ot_a) ot_alert_q <= wd;
            if (is_in_t) in_ov_q <= wd;
            if (is_on) ok_on_q <= wd;
            if (is_off) ok_off_q <= wd;
            if (is_wait) ton_wait_q <= wd;
            if (is_ramp) ton_ramp_q <= wd;
        end
    end

    // Shutdown latch: an output overvoltage, overcurrent or overheat fault with policy 000 stays off until commanded off
    wire latch_set = (out_ov_i & (ov_pol_q == frl_pkg::POLICY_NEVER))
        | (oc_i & (oc_pol_q == frl_pkg::POLICY_NEVER))
        | (ot_i & (ot_pol_q == frl_pkg::POLICY_NEVER));
    always_comb begin
        latch_d = latch_q;
        if (!on_cmd_i) begin
            latch_d = 1'b0;
        end
        if (latch_set) begin
            latch_d = 1'b1;
        end
    end

    // Output enable: any fault drops it at once, policy 111 restarts when clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            latch_q <= 1'b0;
            out_en_q <= 1'b0;
        end else begin
            latch_q <= latch_d;
            out_en_q <= on_cmd_i & ~latch_d & ~out_ov_i & ~oc_i & ~ot_i & ~in_ov_i;
        end
    end

    // Outputs
    assign link.ack = ack_q;
    assign link.rdata = rdata_q;
    assign out_en_o = out_en_q;
    assign oc_trip_o = oc_trip_q;
    assign oc_alert_o = oc_alert_q;
    assign ot_trip_o = ot_trip_q;
    assign ot_alert_o = ot_alert_q;
    assign in_ov_trip_o = in_ov_q;
    assign ok_assert_o = ok_on_q;
    assign ok_deassert_o = ok_off_q;
    assign turn_on_wait_o = ton_wait_q;
    assign ramp_time_o = ton_ramp_q;
endmodule // frl_bank

// ### hdl/frl_host.sv
// Host end: Wishbone classic slave whose registers launch one command
// on the link and report its answer.
// Assumes one clock shared with the register bank end.
module frl_host (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Link to register bank
    frl_link_if.host link
);
    frl_pkg::frl_hstate_t st_q;
    logic ack_q, we_q, done_q, req_q;
    logic [7:0] code_q;
    logic [15:0] wdata_q, rdata_q;
    logic [31:0] dat_q;

    // Bus decode
    wire acc = wb_cyc_i & wb_stb_i & ~ack_q;
    wire bw = wb_cyc_i & wb_stb_i & wb_we_i & ack_q; // Write lands as ack shows
    wire w_ctrl = bw & (wb_adr_i == frl_pkg::HR_CTRL) & wb_sel_i[0];
    wire go = w_ctrl & wb_dat_i[frl_pkg::CTRL_GO] & (st_q == frl_pkg::FRL_H_IDLE);
    wire busy = st_q == frl_pkg::FRL_H_REQ;
    wire [31:0] rd = (wb_adr_i == frl_pkg::HR_CTRL) ? {30'h0000_0000, done_q, busy}
        : (wb_adr_i == frl_pkg::HR_CODE) ? {24'h00_0000, code_q}
        : (wb_adr_i == frl_pkg::HR_WDATA) ? {16'h0000, wdata_q}
        : (wb_adr_i == frl_pkg::HR_RDATA) ? {16'h0000, rdata_q} : 32'h0000_0000;

    // Bus answer one cycle after the strobe
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
        end else begin
            ack_q <= acc;
            if (acc && !wb_we_i) dat_q <= rd;
        end
    end

    // Command setup registers, frozen while busy
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            code_q <= 8'h00;
            wdata_q <= 16'h0000;
            we_q <= 1'b0;
        end else if (!busy) begin
            if (bw && wb_adr_i == frl_pkg::HR_CODE && wb_sel_i[0]) code_q <= wb_dat_i[7:0];
            if (bw && wb_adr_i == frl_pkg::HR_WDATA && wb_sel_i[0]) wdata_q[7:0] <= wb_dat_i[7:0];
            if (bw && wb_adr_i == frl_pkg::HR_WDATA && wb_sel_i[1]) wdata_q[15:8] <= wb_dat_i[15:8];
            if (go) we_q <= wb_dat_i[frl_pkg::CTRL_WE];
        end
    end

    // link sequencer; holds request until the bank answers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= frl_pkg::FRL_H_IDLE;
            req_q <= 1'b0;
            done_q <= 1'b0;
            rdata_q <= 16'h0000;
        end else begin
            case (st_q)
                frl_pkg::FRL_H_IDLE: begin
                    if (go) begin
                        st_q <= frl_pkg::FRL_H_REQ;
                        req_q <= 1'b1;
                        done_q <= 1'b0;
                    end
                end
                frl_pkg::FRL_H_REQ: begin
                    if (link.ack) begin
                        st_q <= frl_pkg::FRL_H_IDLE;
                        req_q <= 1'b0;
                        done_q <= 1'b1;
                        rdata_q <= link.rdata;
                    end
                end
                default: begin
                    st_q <= frl_pkg::FRL_H_IDLE;
                    req_q <= 1'b0;
                end
            endcase
        end
    end

    // Outputs
    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;
    assign link.req = req_q;
    assign link.we = we_q;
    assign link.code = code_q;
    assign link.wdata = wdata_q;
endmodule // frl_host

// ### sim/frl_chk.sv
// Checker: link handshake and reaction byte contents between host and bank.
// Assumes one clock and a synchronous active high reset shared by both ends.
module frl_chk (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Link signals
    input wire logic req,
    input wire logic we,
    input wire logic [7:0] code,
    input wire logic [15:0] wdata,
    input wire logic ack,
    input wire logic [15:0] rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // Read answers by command
    wire rd_ack = ack && !we;
    wire react_rd = rd_ack && (code == frl_pkg::CMD_OUT_OV_REACT
        || code == frl_pkg::CMD_OC_REACT || code == frl_pkg::CMD_OT_REACT);
    a_ack_one_after: assert property (req && !ack |=> ack)
        else $error("link answer not one cycle after request");
    a_ack_cause: assert property (ack |-> req && $past(req) && !$past(ack))
        else $error("link answer without a pending request");
    a_req_release: assert property (ack |=> !req && !ack)
        else $error("request or answer held past the answer");
    a_req_steady: assert property (req && !ack |=> req && $stable(code) && $stable(wdata))
        else $error("request changed before its answer");
    a_write_zero: assert property (ack && we |-> rdata == 16'h0000)
        else $error("write answer carries data");
    a_ov_react: assert property (
        rd_ack && code == frl_pkg::CMD_OUT_OV_REACT |-> rdata[15:6] == 10'h002 && rdata[2:0] == 3'h0)
        else $error("output overvoltage reaction fixed bits wrong");
    a_oc_react: assert property (
        rd_ack && code == frl_pkg::CMD_OC_REACT |-> rdata[15:6] == 10'h003 && rdata[2:0] == 3'h0)
        else $error("output overcurrent reaction fixed bits wrong");
    a_ot_react: assert property (
        rd_ack && code == frl_pkg::CMD_OT_REACT |-> rdata[15:6] == 10'h002 && rdata[2:0] == 3'h0)
        else $error("overheat reaction fixed bits wrong");
    a_in_ov_react: assert property (
        rd_ack && code == frl_pkg::CMD_IN_OV_REACT |-> rdata == 16'h00c0)
        else $error("input overvoltage reaction not fixed");
    a_policy_legal: assert property (
        react_rd |-> rdata[5:3] == 3'h0 || rdata[5:3] == 3'h7)
        else $error("restart policy holds an unsupported value");
    a_oc_range: assert property (
        rd_ack && code == frl_pkg::CMD_OC_TRIP |-> rdata inside {[16'h0014:16'h003c]})
        else $error("overcurrent trip level out of range");
    a_ot_range: assert property (
        rd_ack && code == frl_pkg::CMD_OT_TRIP |-> rdata inside {[16'h0019:16'h008c]})
        else $error("overheat trip level out of range");
endmodule // frl_chk

// ### sim/fault_response_limit_regs_bench.sv
// Testbench: host and register bank joined by the link, driven over Wishbone.
// Assumes a 10 MHz clock and a synchronous active high reset held 10 cycles.
module fault_response_limit_regs_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i;
    logic rst_i;
    logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, on_cmd_i, out_en_o;
    logic [3:0] wb_adr_i, wb_sel_i, flt;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic [15:0] lim_o [9];
    logic [15:0] shadow [logic [7:0]];
    logic [7:0] lim_code [9] = '{8'h46, 8'h4a, 8'h4f, 8'h51, 8'h55, 8'h5e, 8'h5f, 8'h60, 8'h61};
    // Limit writes in order: code, value, accepted
    logic [24:0] lt [$] = '{
        {8'h4a,16'h000a,1'h1}, {8'h46,16'h0014,1'h1}, {8'h46,16'h0013,1'h0},
        {8'h4a,16'h0014,1'h0}, {8'h4a,16'h0009,1'h0}, {8'h46,16'h003d,1'h0},
        {8'h46,16'h003c,1'h1}, {8'h4a,16'h0028,1'h1}, {8'h4a,16'h0029,1'h0},
        {8'h51,16'h0019,1'h1}, {8'h4f,16'h001a,1'h1}, {8'h4f,16'h0018,1'h0},
        {8'h51,16'h001a,1'h0}, {8'h4f,16'h008c,1'h1}, {8'h4f,16'h008d,1'h0},
        {8'h51,16'h007d,1'h1}, {8'h51,16'h007e,1'h0}, {8'h55,16'h002f,1'h0},
        {8'h55,16'h0030,1'h1}, {8'h55,16'h005a,1'h1}, {8'h55,16'h005b,1'h0},
        {8'h5f,16'h032a,1'h1}, {8'h5e,16'h03ca,1'h1}, {8'h5e,16'h03c9,1'h0},
        {8'h5f,16'h032b,1'h0}, {8'h5e,16'h0528,1'h1}, {8'h5f,16'h0488,1'h1},
        {8'h5f,16'h0489,1'h0}, {8'h5e,16'h0529,1'h0}, {8'h5f,16'h0329,1'h0},
        {8'h60,16'h0009,1'h0}, {8'h60,16'h000a,1'h1}, {8'h60,16'h01f4,1'h1},
        {8'h60,16'h01f5,1'h0}, {8'h61,16'h000e,1'h0}, {8'h61,16'h000f,1'h1},
        {8'h61,16'h01f4,1'h1}, {8'h61,16'h01f5,1'h0}};
    int error_cnt = 0;
    int total_checks = 0;
    int cyc_cnt = 0;
    wire out_ov_i, oc_i, ot_i, in_ov_i;
    // Fault levels from one vector
    assign {out_ov_i, oc_i, ot_i, in_ov_i} = flt;
    frl_link_if frl_link_if_i ();
    frl_host frl_host_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .link(frl_link_if_i));
    frl_bank frl_bank_i (.clk_i(clk_i), .rst_i(rst_i), .link(frl_link_if_i),
        .on_cmd_i(on_cmd_i), .out_ov_i(out_ov_i), .oc_i(oc_i), .ot_i(ot_i), .in_ov_i(in_ov_i),
        .out_en_o(out_en_o), .oc_trip_o(lim_o[0]), .oc_alert_o(lim_o[1]), .ot_trip_o(lim_o[2]),
        .ot_alert_o(lim_o[3]), .in_ov_trip_o(lim_o[4]), .ok_assert_o(lim_o[5]),
        .ok_deassert_o(lim_o[6]), .turn_on_wait_o(lim_o[7]), .ramp_time_o(lim_o[8]));
    frl_chk frl_chk_i (.clk_i(clk_i), .rst_i(rst_i), .req(frl_link_if_i.req),
        .we(frl_link_if_i.we), .code(frl_link_if_i.code), .wdata(frl_link_if_i.wdata),
        .ack(frl_link_if_i.ack), .rdata(frl_link_if_i.rdata));
    // Clock
    initial begin
        clk_i = 1'h0;
        forever #50 clk_i = ~clk_i;
    end
    // Cuts a hang short
    always @(posedge clk_i) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 20000) begin
            error_cnt++;
            summarize();
        end
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // One classic Wishbone cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] r);
        @(posedge clk_i);
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do @(posedge clk_i); while (wb_ack_o !== 1'h1);
        r = wb_dat_o;
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
    endtask
    // One link command launched through the host registers
    task automatic cmd(input logic w, input logic [7:0] c, input logic [15:0] d,
                       output logic [15:0] r);
        logic [31:0] x;
        int n;
        wb(1'h1, frl_pkg::HR_CODE, 32'(c), x);
        wb(1'h1, frl_pkg::HR_WDATA, 32'(d), x);
        wb(1'h1, frl_pkg::HR_CTRL, {30'h0000_0000, w, 1'h1}, x);
        n = 0;
        do begin
            wb(1'h0, frl_pkg::HR_CTRL, 32'h0000_0000, x);
            n++;
        end while ((x[frl_pkg::STAT_BUSY] !== 1'h0 || x[frl_pkg::STAT_DONE] !== 1'h1) && n < 20);
        check("command done", x[1:0], 32'h0000_0002);
        wb(1'h0, frl_pkg::HR_RDATA, 32'h0000_0000, x);
        r = x[15:0];
    endtask
    // Reads and then clears the communication status
    task automatic stat(output logic [15:0] r);
        logic [15:0] y;
        cmd(1'h0, frl_pkg::CMD_COMM_STATUS, 16'h0000, r);
        cmd(1'h1, frl_pkg::CMD_COMM_STATUS, 16'h00ff, y);
    endtask
    task automatic t_reset();
        logic [15:0] r;
        foreach (shadow[k]) begin
            cmd(1'h0, k, 16'h0000, r);
            check("reset value", r, shadow[k]);
        end
        cmd(1'h0, 8'h00, 16'h0000, r);
        check("unknown read", r, 16'h0000);
        stat(r);
        check("bad command flag", r, 16'h0080);
        stat(r);
        check("status cleared", r, 16'h0000);
        $display("test reset done");
    endtask
    task automatic t_host();
        logic [31:0] a, b;
        wb(1'h0, 4'h6, 32'h0000_0000, a);
        check("unmapped read", a, 32'h0000_0000);
        wb(1'h0, frl_pkg::HR_RDATA, 32'h0000_0000, a);
        wb(1'h1, frl_pkg::HR_RDATA, 32'hffff_ffff, b);
        wb(1'h0, frl_pkg::HR_RDATA, 32'h0000_0000, b);
        check("read only data", b, 32'h0000_0000);
        $display("test host done");
    endtask
    task automatic t_react();
        logic [7:0] rc [3] = '{8'h41, 8'h47, 8'h50};
        logic [15:0] r;
        foreach (rc[i]) begin
            cmd(1'h1, rc[i], 16'h0007, r);
            cmd(1'h0, rc[i], 16'h0000, r);
            check("policy never", r, shadow[rc[i]] & 16'h00c7);
            cmd(1'h1, rc[i], 16'h0010, r);
            cmd(1'h0, rc[i], 16'h0000, r);
            check("policy kept", r, shadow[rc[i]] & 16'h00c7);
            stat(r);
            check("policy flag", r, 16'h0040);
            cmd(1'h1, rc[i], 16'h00ff, r);
            cmd(1'h0, rc[i], 16'h0000, r);
            check("policy always", r, shadow[rc[i]]);
        end
        cmd(1'h1, 8'h56, 16'h003f, r);
        cmd(1'h0, 8'h56, 16'h0000, r);
        check("input reaction", r, 16'h00c0);
        stat(r);
        check("input reaction flag", r, 16'h0000);
        $display("test reaction done");
    endtask
    task automatic t_limits();
        logic [15:0] r;
        foreach (lt[i]) begin
            cmd(1'h1, lt[i][24:17], lt[i][16:1], r);
            if (lt[i][0]) shadow[lt[i][24:17]] = lt[i][16:1];
            cmd(1'h0, lt[i][24:17], 16'h0000, r);
            check("limit", r, shadow[lt[i][24:17]]);
            stat(r);
            check("limit flag", r, lt[i][0] ? 16'h0000 : 16'h0040);
        end
        foreach (lim_code[i]) begin
            check("limit port", lim_o[i], shadow[lim_code[i]]);
        end
        $display("test limits done");
    endtask
    task automatic t_fault();
        logic [15:0] r;
        @(posedge clk_i);
        on_cmd_i <= 1'h1;
        repeat (2) @(negedge clk_i);
        check("output on", out_en_o, 1'h1);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_i);
            flt <= 4'h1 << i;
            repeat (2) @(negedge clk_i);
            check("fault off", out_en_o, 1'h0);
            @(posedge clk_i);
            flt <= 4'h0;
            repeat (2) @(negedge clk_i);
            check("restart", out_en_o, 1'h1);
        end
        cmd(1'h1, 8'h41, 16'h0000, r);
        @(posedge clk_i);
        flt <= 4'h8;
        @(posedge clk_i);
        flt <= 4'h0;
        repeat (3) @(negedge clk_i);
        check("latched off", out_en_o, 1'h0);
        @(posedge clk_i);
        on_cmd_i <= 1'h0;
        @(posedge clk_i);
        on_cmd_i <= 1'h1;
        repeat (2) @(negedge clk_i);
        check("on again", out_en_o, 1'h1);
        cmd(1'h1, 8'h41, 16'h00ff, r);
        $display("test fault done");
    endtask
    // Main sequence
    initial begin
        rst_i = 1'h1;
        wb_cyc_i = 1'h0;
        wb_stb_i = 1'h0;
        wb_we_i = 1'h0;
        wb_adr_i = 4'h0;
        wb_sel_i = 4'hf;
        wb_dat_i = 32'h0000_0000;
        on_cmd_i = 1'h0;
        flt = 4'h0;
        shadow[8'h41] = 16'h00b8;
        shadow[8'h46] = 16'h0032;
        shadow[8'h47] = 16'h00f8;
        shadow[8'h4a] = 16'h0028;
        shadow[8'h4f] = 16'h007d;
        shadow[8'h50] = 16'h00b8;
        shadow[8'h51] = 16'h006e;
        shadow[8'h55] = 16'h004b;
        shadow[8'h56] = 16'h00c0;
        shadow[8'h5e] = 16'h044c;
        shadow[8'h5f] = 16'h03ac;
        shadow[8'h60] = 16'h000a;
        shadow[8'h61] = 16'h000f;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'h0;
        t_reset();
        t_host();
        t_react();
        t_limits();
        t_fault();
        summarize();
    end
endmodule // fault_response_limit_regs_bench
